// ==== core/pjad_defines.vh ====
// Register indices, field positions, reset values and timing counts for the port J/AD block.
`ifndef PJAD_DEFINES_VH
`define PJAD_DEFINES_VH

// Register indices. Each register's byte address is four times its index.
`define PJAD_IDX_J_DRIVE_REDUCE 6'h2b
`define PJAD_IDX_J_PULL_ENABLE 6'h2c
`define PJAD_IDX_J_POLARITY_SELECT 6'h2d
`define PJAD_IDX_J_IRQ_ENABLE 6'h2e
`define PJAD_IDX_J_IRQ_FLAGS 6'h2f
`define PJAD_IDX_AD_DATA 6'h30
`define PJAD_IDX_AD_PIN_INPUT 6'h31
`define PJAD_IDX_AD_DIRECTION 6'h32

// Port J bits occupy positions 7 and 6 of each byte-wide register.
`define PJAD_J_MSB 7
`define PJAD_J_LSB 6

// Reset values.
`define PJAD_RST_J 2'h0
`define PJAD_RST_AD 8'h00
`define PJAD_RST_RDATA 32'h0000_0000

// Stages of input synchronisation, and samples needed before edges are trusted.
`define PJAD_SYNC_STAGES 2
`define PJAD_ARM_COUNT 2'h3

`endif

// ==== core/pjad_sync.v ====
// Two-flop synchroniser for a bus of pin inputs.
module pjad_sync #(
  parameter W = 8
) (
  input wire core_clk,
  input wire reset,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta;

  // The first stage feeds only the second, so a metastable value never reaches logic.
  always @(posedge core_clk) begin
    if (reset) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ==== core/pjad_edge_flags.v ====
// Edge detector with sticky write-one-to-clear flags for the port J pins.
`include "pjad_defines.vh"

module pjad_edge_flags #(
  parameter W = 2
) (
  input wire core_clk,
  input wire reset,
  input wire ce,
  input wire [W-1:0] sample,
  input wire [W-1:0] polarity,
  input wire [W-1:0] clear,
  output reg [W-1:0] flags
);

  reg [W-1:0] prev;
  reg [1:0] arm_cnt;
  wire armed;
  wire [W-1:0] rise;
  wire [W-1:0] fall;
  wire [W-1:0] hit;

  // Edges are ignored until the synchroniser and the previous sample hold real pin levels;
  // otherwise a pin that sits high out of reset would look like a rising edge.
  assign armed = (arm_cnt == `PJAD_ARM_COUNT);
  assign rise = sample & ~prev;
  assign fall = ~sample & prev;
  assign hit = ((rise & polarity) | (fall & ~polarity)) & {W{armed}};

  // Arming counter and last-sample register.
  always @(posedge core_clk) begin
    if (reset) begin
      prev <= {W{1'b0}};
      arm_cnt <= 2'h0;
    end else if (ce) begin
      prev <= sample;
      if (!armed) begin
        arm_cnt <= arm_cnt + 2'h1;
      end
    end
  end

  // A new edge in the same cycle as a clearing write keeps the flag set.
  always @(posedge core_clk) begin
    if (reset) begin
      flags <= {W{1'b0}};
    end else if (ce) begin
      flags <= (flags & ~clear) | hit;
    end
  end

endmodule

// ==== core/pjad_gpio.v ====
// Port J pad control with edge interrupts and port AD data/direction, on classic Wishbone.
`include "pjad_defines.vh"

module pjad_gpio #(
  parameter J_W = 2,
  parameter AD_W = 8
) (
  input wire core_clk,
  input wire reset,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire irq,
  input wire [J_W-1:0] pj_pin_in,
  input wire [J_W-1:0] pj_gpio_dir,
  input wire [J_W-1:0] pj_wired_or,
  input wire [J_W-1:0] pj_periph_en,
  input wire [J_W-1:0] pj_periph_oe,
  output reg [J_W-1:0] pj_drive_reduced,
  output reg [J_W-1:0] pj_pull_up,
  output reg [J_W-1:0] pj_pull_down,
  input wire [AD_W-1:0] pad_pin_in,
  input wire [AD_W-1:0] pad_periph_en,
  input wire [AD_W-1:0] pad_periph_out,
  input wire [AD_W-1:0] pad_periph_oe,
  output reg [AD_W-1:0] pad_pin_out,
  output reg [AD_W-1:0] pad_pin_oe
);

  // Bus states, one-hot.
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_ACK = 2'b10;

  // Register map, given as word indices on the bus.
  // A register's byte address is four times its index, and bits 1:0 of the address are ignored.
  // Index 0x2b holds the port J drive-reduce bits in data bits 7:6.
  // Index 0x2c holds the port J pull-enable bits in data bits 7:6.
  // Index 0x2d holds the port J polarity bits in data bits 7:6.
  // Polarity picks both the active edge and the direction of the pull.
  // Index 0x2e holds the port J interrupt-enable bits in data bits 7:6.
  // Index 0x2f holds the port J edge flags, which are cleared by writing ones.
  // Index 0x30 holds the port AD data latch in data bits 7:0.
  // Index 0x31 is the port AD pin-input view; it has no storage.
  // Index 0x32 holds the port AD direction bits, where one means output.
  // Every other index reads as zero and ignores writes, but still acknowledges.
  // Bits of a read word that no field occupies always read as zero.
  // Only byte lane 0 carries write data, so a write with sel[0] low changes nothing.

  // Bus timing, as seen by a classic master.
  // A request is taken at the first rising edge on which cyc and stb are high in idle.
  // Ack is high for exactly one cycle after that edge.
  // A write lands at the edge where the master sees ack high.
  // Read data is captured when the request is taken and stands until the next read.
  // The machine rests in idle for one cycle after each ack, so a master that keeps
  // its request up is answered every other cycle; it must not count on a fixed delay.

  // Clock enable.
  // With ce low every flop holds, including the bus machine, the synchronisers and the
  // arming counter, so a frozen block takes no new request, keeps an ack that is already up high, and records no pin edges.

  // True when a word address selects the register at the given index.
  function hit_index;
    input [7:0] adr;
    input [5:0] idx;
    begin
      hit_index = (adr[7:2] == idx);
    end
  endfunction

  // Places a port J field at bits 7:6 of a read word, the rest zero.
  function [31:0] j_word;
    input [1:0] field;
    begin
      j_word = {24'h00_0000, field, 6'h00};
    end
  endfunction

  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] next_dat;

  reg [J_W-1:0] j_drive_reduce;
  reg [J_W-1:0] j_pull_enable;
  reg [J_W-1:0] j_polarity;
  reg [J_W-1:0] j_irq_enable;
  reg [AD_W-1:0] ad_data;
  reg [AD_W-1:0] ad_dir;

  reg [J_W-1:0] next_drive_reduced;
  reg [J_W-1:0] next_pull_up;
  reg [J_W-1:0] next_pull_down;
  reg [AD_W-1:0] next_pin_out;
  reg [AD_W-1:0] next_pin_oe;

  wire [J_W-1:0] j_sync;
  wire [AD_W-1:0] ad_sync;
  wire [J_W-1:0] j_flags;
  wire [J_W-1:0] j_clear;
  wire [J_W-1:0] j_is_out;
  wire [J_W-1:0] j_pull_active;
  wire [AD_W-1:0] ad_read_data;
  wire req;
  wire commit;
  wire wr_lane0;

  // Pin levels cross into the clock domain through two flops; with the registered pad drive,
  // this is why reads can trail a direction change by up to three cycles.
  pjad_sync #(
    .W(J_W)
  ) u_sync_j (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .d(pj_pin_in),
    .q(j_sync)
  );

  pjad_sync #(
    .W(AD_W)
  ) u_sync_ad (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .d(pad_pin_in),
    .q(ad_sync)
  );

  // Edge detection and sticky flags for port J.
  pjad_edge_flags #(
    .W(J_W)
  ) u_flags (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .sample(j_sync),
    .polarity(j_polarity),
    .clear(j_clear),
    .flags(j_flags)
  );

  // A request is taken in idle; the access commits at the edge where ack is seen high.
  assign req = wb_cyc_i & wb_stb_i;
  assign commit = (state == S_ACK) & req;
  assign wr_lane0 = commit & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = (state == S_ACK);

  // Write-one-to-clear pulse for the flag register; zero bits leave flags alone.
  assign j_clear = (wr_lane0 && hit_index(wb_adr_i, `PJAD_IDX_J_IRQ_FLAGS)) ?
                   wb_dat_i[`PJAD_J_MSB:`PJAD_J_LSB] : {J_W{1'b0}};

  // The interrupt is a level that follows the masked flags directly.
  assign irq = |(j_flags & j_irq_enable);

  // Output pins return the latch, inputs return the synchronised pin.
  assign ad_read_data = (ad_dir & ad_data) | (~ad_dir & ad_sync);

  // Port J pin counts as an output when its owner, peripheral or gpio, drives it.
  assign j_is_out = (pj_periph_en & pj_periph_oe) | (~pj_periph_en & pj_gpio_dir);

  // Pulls act on inputs, and a pull-up also on wired-or outputs; never on a push-pull output.
  assign j_pull_active = j_pull_enable & (~j_is_out | pj_wired_or);

  // Bus state sequencing: one idle cycle between accesses, ack for one cycle.
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (req) begin
          next_state = S_ACK;
        end
      end
      S_ACK: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Read data is sampled when the request is taken and held through the ack cycle.
  // Unmapped addresses read as zero and writes to them are dropped.
  always @* begin
    next_dat = `PJAD_RST_RDATA;
    if (hit_index(wb_adr_i, `PJAD_IDX_J_DRIVE_REDUCE)) begin
      next_dat = j_word(j_drive_reduce);
    end else if (hit_index(wb_adr_i, `PJAD_IDX_J_PULL_ENABLE)) begin
      next_dat = j_word(j_pull_enable);
    end else if (hit_index(wb_adr_i, `PJAD_IDX_J_POLARITY_SELECT)) begin
      next_dat = j_word(j_polarity);
    end else if (hit_index(wb_adr_i, `PJAD_IDX_J_IRQ_ENABLE)) begin
      next_dat = j_word(j_irq_enable);
    end else if (hit_index(wb_adr_i, `PJAD_IDX_J_IRQ_FLAGS)) begin
      next_dat = j_word(j_flags);
    end else if (hit_index(wb_adr_i, `PJAD_IDX_AD_DATA)) begin
      next_dat = {24'h00_0000, ad_read_data};
    end else if (hit_index(wb_adr_i, `PJAD_IDX_AD_PIN_INPUT)) begin
      next_dat = {24'h00_0000, ad_sync};
    end else if (hit_index(wb_adr_i, `PJAD_IDX_AD_DIRECTION)) begin
      next_dat = {24'h00_0000, ad_dir};
    end
  end

  // Bus state and read data registers.
  always @(posedge core_clk) begin
    if (reset) begin
      state <= S_IDLE;
      wb_dat_o <= `PJAD_RST_RDATA;
    end else if (ce) begin
      state <= next_state;
      if ((state == S_IDLE) && req && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // Port J configuration registers. Only bits 7:6 of the written byte are kept,
  // since the port has just two pins; the other bits of the word are dropped.
  always @(posedge core_clk) begin
    if (reset) begin
      j_drive_reduce <= `PJAD_RST_J;
      j_pull_enable <= `PJAD_RST_J;
      j_polarity <= `PJAD_RST_J;
      j_irq_enable <= `PJAD_RST_J;
    end else if (ce && wr_lane0) begin
      if (hit_index(wb_adr_i, `PJAD_IDX_J_DRIVE_REDUCE)) begin
        j_drive_reduce <= wb_dat_i[`PJAD_J_MSB:`PJAD_J_LSB];
      end
      if (hit_index(wb_adr_i, `PJAD_IDX_J_PULL_ENABLE)) begin
        j_pull_enable <= wb_dat_i[`PJAD_J_MSB:`PJAD_J_LSB];
      end
      if (hit_index(wb_adr_i, `PJAD_IDX_J_POLARITY_SELECT)) begin
        j_polarity <= wb_dat_i[`PJAD_J_MSB:`PJAD_J_LSB];
      end
      if (hit_index(wb_adr_i, `PJAD_IDX_J_IRQ_ENABLE)) begin
        j_irq_enable <= wb_dat_i[`PJAD_J_MSB:`PJAD_J_LSB];
      end
    end
  end

  // Port AD registers. The pin input register has no storage, so a write
  // to it falls through every branch and is discarded.
  // The data latch is written whatever the direction, so software can preload
  // a value before it turns a pin into an output.
  always @(posedge core_clk) begin
    if (reset) begin
      ad_data <= `PJAD_RST_AD;
      ad_dir <= `PJAD_RST_AD;
    end else if (ce && wr_lane0) begin
      if (hit_index(wb_adr_i, `PJAD_IDX_AD_DATA)) begin
        ad_data <= wb_dat_i[AD_W-1:0];
      end
      if (hit_index(wb_adr_i, `PJAD_IDX_AD_DIRECTION)) begin
        ad_dir <= wb_dat_i[AD_W-1:0];
      end
    end
  end

  // Port J pad controls. Reduced drive only matters on an output; a pull-up serves
  // inputs and wired-or outputs, while a pull-down is limited to inputs.
  always @* begin
    next_drive_reduced = j_drive_reduce & j_is_out;
    next_pull_up = j_pull_active & ~j_polarity;
    next_pull_down = j_pull_active & j_polarity & ~j_is_out;
  end

  // Port AD pad drive. A peripheral that owns a pin overrides the direction bit,
  // and the latch value only reaches a pin that is a gpio output.
  always @* begin
    next_pin_oe = (pad_periph_en & pad_periph_oe) | (~pad_periph_en & ad_dir);
    next_pin_out = (pad_periph_en & pad_periph_out) |
                   (~pad_periph_en & ad_dir & ad_data);
  end

  // Port J pad controls leave through flops so the pads see no decode glitches,
  // at the cost of one cycle of latency after a register write.
  always @(posedge core_clk) begin
    if (reset) begin
      pj_drive_reduced <= `PJAD_RST_J;
      pj_pull_up <= `PJAD_RST_J;
      pj_pull_down <= `PJAD_RST_J;
    end else if (ce) begin
      pj_drive_reduced <= next_drive_reduced;
      pj_pull_up <= next_pull_up;
      pj_pull_down <= next_pull_down;
    end
  end

  // Port AD pad drive is registered in the same way.
  // Out of reset every pin is an undriven input with a low output value.
  always @(posedge core_clk) begin
    if (reset) begin
      pad_pin_out <= `PJAD_RST_AD;
      pad_pin_oe <= `PJAD_RST_AD;
    end else if (ce) begin
      pad_pin_out <= next_pin_out;
      pad_pin_oe <= next_pin_oe;
    end
  end

endmodule

// ==== tb/pjad_asserts.sv ====
// Checker of bus handshake and pad control rules at the pjad_gpio ports.
module pjad_asserts #(
  parameter J_W = 2
) (
  input wire core_clk,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire [J_W-1:0] pj_gpio_dir,
  input wire [J_W-1:0] pj_wired_or,
  input wire [J_W-1:0] pj_periph_en,
  input wire [J_W-1:0] pj_periph_oe,
  input wire [J_W-1:0] pj_drive_reduced,
  input wire [J_W-1:0] pj_pull_up,
  input wire [J_W-1:0] pj_pull_down
);
  timeunit 1ns;
  timeprecision 1ns;
  // Effective port J output state; a peripheral that owns the pin overrides direction.
  wire [J_W-1:0] pj_out = (pj_periph_en & pj_periph_oe) | (~pj_periph_en & pj_gpio_dir);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // A request taken while idle gets exactly one ack cycle.
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_answer: assert property (s_taken |=> s_ack_pulse)
    else $error("ack pulse missing after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_idle_no_ack: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack while bus idle");
  // Pad controls are registered, so they follow the previous cycle's pin state.
  a_drive_output: assert property (!$past(reset) |->
    (pj_drive_reduced & ~$past(pj_out)) == 0)
    else $error("reduced drive on input pin");
  a_pull_pushpull: assert property (!$past(reset) |->
    (pj_pull_up & $past(pj_out) & ~$past(pj_wired_or)) == 0)
    else $error("pull-up on push-pull output");
  a_pulldown_input: assert property (!$past(reset) |->
    (pj_pull_down & $past(pj_out)) == 0)
    else $error("pull-down on output pin");
  a_pull_single: assert property ((pj_pull_up & pj_pull_down) == 0)
    else $error("both pulls active");
  // Every register is a byte, so an answered access never shows upper data bits.
  a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0)
    else $error("read data upper bits set");
endmodule

bind pjad_gpio pjad_asserts #(.J_W(J_W)) chk (
  .core_clk(core_clk),
  .reset(reset),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o),
  .pj_gpio_dir(pj_gpio_dir),
  .pj_wired_or(pj_wired_or),
  .pj_periph_en(pj_periph_en),
  .pj_periph_oe(pj_periph_oe),
  .pj_drive_reduced(pj_drive_reduced),
  .pj_pull_up(pj_pull_up),
  .pj_pull_down(pj_pull_down)
);

// ==== tb/pjad_pins.sv ====
// Behavioural model of the external pins of both ports.
module pjad_pins (
  input wire [7:0] pad_pin_out,
  input wire [7:0] pad_pin_oe,
  input wire [7:0] ext_ad,
  input wire [1:0] ext_j,
  output logic [7:0] pad_pin_in,
  output logic [1:0] pj_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A driven pad shows its own value, an undriven one the outside circuit.
  assign pad_pin_in = (pad_pin_oe & pad_pin_out) | (~pad_pin_oe & ext_ad);
  // Port J pins are only driven from outside here.
  assign pj_pin_in = ext_j;
endmodule

// ==== tb/pjad_gpio_tb.sv ====
// Self-checking bench for the port J/AD block.
`include "pjad_defines.vh"
module pjad_gpio_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, cyc, stb, we;
  logic [7:0] adr, ext_ad, pen, pout, poe, d, v, e, r;
  logic [31:0] wdat, lfsr;
  logic [1:0] ext_j, jdir, jwo, jpen, jpoe, o;
  wire [31:0] rdat;
  wire ack, irq;
  wire [1:0] pj_in, drv, pu, pd;
  wire [7:0] pad_in, pad_out, pad_oe;
  logic [31:0] expq[$];
  int mismatches, checks, cyc_n;

  pjad_gpio uut (.core_clk(core_clk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .pj_pin_in(pj_in), .pj_gpio_dir(jdir),
    .pj_wired_or(jwo), .pj_periph_en(jpen), .pj_periph_oe(jpoe), .pj_drive_reduced(drv),
    .pj_pull_up(pu), .pj_pull_down(pd), .pad_pin_in(pad_in), .pad_periph_en(pen),
    .pad_periph_out(pout), .pad_periph_oe(poe), .pad_pin_out(pad_out), .pad_pin_oe(pad_oe));
  pjad_pins pins (.pad_pin_out(pad_out), .pad_pin_oe(pad_oe), .ext_ad(ext_ad),
    .ext_j(ext_j), .pad_pin_in(pad_in), .pj_pin_in(pj_in));

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic cycle; on a read, x is the expected byte.
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] x);
    if (!w) expq.push_back({24'h0000_00, x});
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0000_00, x};
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    cyc <= 0;
    stb <= 0;
    @(posedge core_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  // Read answers are matched in order against the noted expectations.
  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      mismatches++;
      finish_test();
    end
    if (ack === 1'b1 && cyc && !we) cmp("read data", expq.pop_front(), rdat);
  end

  initial begin
    {cyc, stb, we, adr, wdat, ext_ad, pen, pout, poe} = 0;
    {ext_j, jdir, jwo, jpen, jpoe} = 0;
    lfsr = 32'h0000_9dee;
    reset = 1;
    repeat (3) @(posedge core_clk);
    reset <= 0;
    repeat (4) @(posedge core_clk);
    // Every register reads zero after reset; 0x33 is unmapped.
    for (int i = 'h2b; i <= 'h33; i++) bus(0, i[5:0], 8'h00);
    $display("test reset done");
    repeat (4) begin
      d = rnd();
      v = rnd();
      e = rnd();
      ext_ad <= e;
      bus(1, `PJAD_IDX_AD_DIRECTION, d);
      bus(1, `PJAD_IDX_AD_DATA, v);
      bus(1, `PJAD_IDX_AD_PIN_INPUT, ~e);
      repeat (3) @(posedge core_clk);
      bus(0, `PJAD_IDX_AD_DATA, (v & d) | (e & ~d));
      bus(0, `PJAD_IDX_AD_PIN_INPUT, (v & d) | (e & ~d));
      cmp("pad_oe", d, pad_oe);
      cmp("pad_out", v & d, pad_out);
    end
    pen <= rnd();
    pout <= rnd();
    poe <= rnd();
    repeat (2) @(posedge core_clk);
    cmp("pad_oe periph", (pen & poe) | (~pen & d), pad_oe);
    cmp("pad_out periph", (pen & pout) | (~pen & v & d), pad_out);
    $display("test port ad done");
    bus(1, `PJAD_IDX_J_POLARITY_SELECT, 8'h80);
    ext_j <= 2'b01;
    repeat (4) @(posedge core_clk);
    bus(0, `PJAD_IDX_J_IRQ_FLAGS, 8'h00);
    bus(1, `PJAD_IDX_J_IRQ_ENABLE, 8'hc0);
    ext_j <= 2'b10;
    repeat (4) @(posedge core_clk);
    bus(0, `PJAD_IDX_J_IRQ_FLAGS, 8'hc0);
    cmp("irq", 1, irq);
    bus(1, `PJAD_IDX_J_IRQ_ENABLE, 8'h40);
    bus(1, `PJAD_IDX_J_IRQ_FLAGS, 8'h40);
    bus(0, `PJAD_IDX_J_IRQ_FLAGS, 8'h80);
    cmp("irq masked", 0, irq);
    bus(1, `PJAD_IDX_J_IRQ_ENABLE, 8'hc0);
    cmp("irq enabled", 1, irq);
    bus(1, `PJAD_IDX_J_IRQ_FLAGS, 8'h00);
    bus(0, `PJAD_IDX_J_IRQ_FLAGS, 8'h80);
    bus(1, `PJAD_IDX_J_IRQ_FLAGS, 8'h80);
    cmp("irq cleared", 0, irq);
    $display("test edges done");
    repeat (8) begin
      r = rnd();
      jdir <= r[1:0];
      jwo <= r[3:2];
      jpen <= r[5:4];
      jpoe <= r[7:6];
      d = rnd();
      v = rnd();
      e = rnd();
      bus(1, `PJAD_IDX_J_DRIVE_REDUCE, d);
      bus(1, `PJAD_IDX_J_PULL_ENABLE, v);
      bus(1, `PJAD_IDX_J_POLARITY_SELECT, e);
      @(posedge core_clk);
      o = (jpen & jpoe) | (~jpen & jdir);
      cmp("drive", d[7:6] & o, drv);
      cmp("pull_up", v[7:6] & ~e[7:6] & (~o | jwo), pu);
      cmp("pull_down", v[7:6] & e[7:6] & ~o, pd);
    end
    $display("test pads done");
    finish_test();
  end
endmodule
